/* File: src/scan_device.sv */
`timescale 1ns/10ps
`default_nettype none
module scan_device (
	input wire logic clk,
	input wire logic reset_n,
	scan_if.dev link,
	output logic [2:0] mux_sel,
	output logic ref_sel,
	output logic [1:0] gain_sel,
	output logic conv_start,
	input wire logic conv_done,
	input wire logic signed [15:0] conv_data,
	input wire logic term_present,
	output logic fault
);
	typedef enum {S_IDLE, S_SETTLE, S_CONV, S_PUSH} state_t;
	state_t st_r, st_nxt;
	logic [2:0] slot_r, slot_nxt;
	logic ref_r, ref_nxt;
	logic [19:0] tmr_r, tmr_nxt;
	logic [19:0] wd_r, wd_nxt;
	logic [2:0] range_r [8];
	logic signed [15:0] align_r [8];
	logic signed [15:0] low_r [8];
	logic signed [15:0] high_r [8];
	logic signed [31:0] filt_r [8];
	logic signed [15:0] ref_off_r, ref_off_nxt;
	logic [2:0] mux_r, mux_nxt;
	logic [1:0] gain_r, gain_nxt;
	logic start_r, start_nxt, done_r, done_nxt, fault_r, fault_nxt;
	logic push;
	logic [4:0] stat;
	logic signed [15:0] corr, scaled, clamped;
	logic signed [31:0] filt_new;
	logic [23:0] fifo_in;
	logic fifo_ready, fifo_valid;
	logic [23:0] fifo_out;
	logic [3:0] shift;
	logic [2:0] nxt_ch, first_ch;
	logic found;
	logic signed [15:0] raw_r, raw_nxt;
	logic sent_r, sent_nxt;

	// Pick the next slot: normal visits every channel, fast only in-use ones, reference last
	always_comb begin
		nxt_ch = 3'h0;
		first_ch = 3'h0;
		found = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			// Lowest eligible channel, searched from scratch for the start of a cycle
			if (!link.fast_mode || link.in_use[i]) begin
				first_ch = 3'(i);
			end
			if (i > int'(slot_r) && (!link.fast_mode || link.in_use[i])) begin
				nxt_ch = 3'(i);
				found = 1'b1;
			end
		end
	end

	// Corrections, filter, clamp for the channel just converted
	always_comb begin
		corr = raw_r - ref_off_r + align_r[slot_r];
		unique case (link.filter_sel)
			3'h1: shift = 4'h2;
			3'h2: shift = 4'h3;
			3'h3: shift = 4'h4;
			3'h4: shift = 4'h5;
			3'h5: shift = 4'h6;
			3'h6: shift = 4'h7;
			default: shift = 4'h0;
		endcase
		// Alpha = 1 - 2^-shift; shifts approximate the seven documented settings
		if (link.fast_mode || shift == 4'h0) begin
			filt_new = 32'(corr) <<< 8;
		end else begin
			filt_new = filt_r[slot_r] - (filt_r[slot_r] >>> shift) + ((32'(corr) <<< 8) >>> shift);
		end
		scaled = 16'(filt_new >>> 8);
		stat = '0;
		clamped = scaled;
		if (scaled < low_r[slot_r]) begin
			clamped = low_r[slot_r];
			stat[scan_pkg::ST_UNDER] = 1'b1;
		end else if (scaled > high_r[slot_r]) begin
			clamped = high_r[slot_r];
			stat[scan_pkg::ST_OVER] = 1'b1;
		end
		stat[scan_pkg::ST_TERM] = !term_present;
		stat[scan_pkg::ST_WDOG] = fault_r;
		fifo_in = {5'(stat), slot_r, clamped};
	end

	// Slot sequencer
	always_comb begin
		st_nxt = st_r;
		slot_nxt = slot_r;
		ref_nxt = ref_r;
		tmr_nxt = tmr_r + 20'h1;
		start_nxt = 1'b0;
		done_nxt = 1'b0;
		mux_nxt = mux_r;
		gain_nxt = gain_r;
		ref_off_nxt = ref_off_r;
		push = 1'b0;
		raw_nxt = raw_r;
		sent_nxt = sent_r;
		wd_nxt = (st_r == S_CONV) ? wd_r + 20'h1 : 20'h0;
		fault_nxt = fault_r || (wd_r == 20'(scan_pkg::WDOG_CYCLES));
		unique case (st_r)
			S_IDLE: begin
				st_nxt = S_SETTLE;
				ref_nxt = 1'b0;
				slot_nxt = first_ch;
				tmr_nxt = '0;
				if (link.fast_mode && link.in_use == 8'h00) begin
					ref_nxt = 1'b1;
				end
			end
			S_SETTLE: begin
				mux_nxt = slot_r;
				gain_nxt = ref_r ? 2'h0 : (range_r[slot_r] == scan_pkg::RANGE_BIP10 ? 2'h1 :
					(range_r[slot_r] >= scan_pkg::RANGE_MA20 ? 2'h2 : 2'h3));
				st_nxt = S_CONV;
				start_nxt = 1'b1;
				sent_nxt = 1'b0;
			end
			S_CONV: begin
				if (conv_done) begin
					// Converter data is only valid with the done strobe, so hold it here
					raw_nxt = conv_data;
					st_nxt = S_PUSH;
				end
				if (wd_r == 20'(scan_pkg::WDOG_CYCLES)) begin
					st_nxt = S_PUSH;
				end
			end
			S_PUSH: begin
				// One entry per channel slot, none for the reference slot; a full buffer stretches the slot until it is taken
				if (!sent_r) begin
					if (ref_r) begin
						ref_off_nxt = raw_r;
						sent_nxt = 1'b1;
					end else begin
						push = fifo_ready;
						sent_nxt = fifo_ready;
					end
				end
				if (tmr_r >= 20'(link.fast_mode ? scan_pkg::SLOT_CYCLES : scan_pkg::NORMAL_SLOT_CYCLES) - 20'h1
					&& sent_nxt) begin
					tmr_nxt = '0;
					st_nxt = S_SETTLE;
					if (ref_r) begin
						st_nxt = S_IDLE;
						done_nxt = 1'b1;
					end else if (found) begin
						slot_nxt = nxt_ch;
					end else begin
						ref_nxt = 1'b1;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= S_IDLE;
			slot_r <= '0;
			ref_r <= 1'b0;
			tmr_r <= '0;
			wd_r <= '0;
			mux_r <= '0;
			gain_r <= '0;
			start_r <= 1'b0;
			done_r <= 1'b0;
			fault_r <= 1'b0;
			ref_off_r <= '0;
			raw_r <= '0;
			sent_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			slot_r <= slot_nxt;
			ref_r <= ref_nxt;
			tmr_r <= tmr_nxt;
			wd_r <= wd_nxt;
			mux_r <= mux_nxt;
			gain_r <= gain_nxt;
			start_r <= start_nxt;
			done_r <= done_nxt;
			fault_r <= fault_nxt;
			ref_off_r <= ref_off_nxt;
			raw_r <= raw_nxt;
			sent_r <= sent_nxt;
		end
	end

	// Per-channel config and filter state; a write touches only its own channel
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < 8; i++) begin
				range_r[i] <= scan_pkg::RANGE_BIP10;
				align_r[i] <= '0;
				low_r[i] <= 16'sh8000;
				high_r[i] <= 16'sh7fff;
				filt_r[i] <= '0;
			end
		end else begin
			if (link.cfg_we) begin
				range_r[link.cfg_ch] <= link.cfg_range;
				align_r[link.cfg_ch] <= link.cfg_align;
				low_r[link.cfg_ch] <= link.cfg_low;
				high_r[link.cfg_ch] <= link.cfg_high;
			end
			if (push) begin
				filt_r[slot_r] <= filt_new;
			end
		end
	end

	sample_fifo #(.WIDTH(24), .DEPTH(scan_pkg::FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.reset_n(reset_n),
		.in_valid(push),
		.in_ready(fifo_ready),
		.in_data(fifo_in),
		.out_valid(fifo_valid),
		.out_ready(link.smp_ready),
		.out_data(fifo_out)
	);

	assign link.smp_valid = fifo_valid;
	assign link.smp_ch = fifo_out[18:16];
	assign link.smp_value = fifo_out[15:0];
	assign link.smp_status = fifo_out[23:19];
	assign link.cycle_done = done_r;
	assign mux_sel = mux_r;
	assign ref_sel = ref_r;
	assign gain_sel = gain_r;
	assign conv_start = start_r;
	assign fault = fault_r;
endmodule
`default_nettype wire

/* File: src/scan_pkg.sv */
package scan_pkg;
	localparam int NUM_CH = 8;
	localparam int DATA_W = 16;
	localparam int FIFO_DEPTH = 8;
	localparam int CLK_PERIOD_PS = 25000;
	// Slot time: fast cycle per-slot figure, normal cycle fixed total over nine slots
	localparam int SLOT_TIME_PS = 3300000;
	localparam int NORMAL_CYCLE_PS = 29700000;
	localparam int SLOT_CYCLES = SLOT_TIME_PS / CLK_PERIOD_PS;
	localparam int NORMAL_SLOT_CYCLES = NORMAL_CYCLE_PS / ((NUM_CH + 1) * CLK_PERIOD_PS);
	localparam int WDOG_CYCLES = 4 * SLOT_CYCLES;
	localparam logic [2:0] RANGE_BIP10 = 3'h0;
	localparam logic [2:0] RANGE_UNI10 = 3'h1;
	localparam logic [2:0] RANGE_UNI5 = 3'h2;
	localparam logic [2:0] RANGE_1_5 = 3'h3;
	localparam logic [2:0] RANGE_MA20 = 3'h4;
	localparam logic [2:0] RANGE_MA4_20 = 3'h5;
	localparam logic [2:0] REF_SLOT = 3'h7;
	localparam logic [2:0] FILTER_MAX = 3'h6;
	// Status bit positions
	localparam int ST_UNDER = 0;
	localparam int ST_OVER = 1;
	localparam int ST_CHAIN = 2;
	localparam int ST_TERM = 3;
	localparam int ST_WDOG = 4;
	localparam int ST_W = 5;
endpackage

/* File: src/scan_if.sv */
`timescale 1ns/10ps
`default_nettype none
// Host-to-module link: per-channel config plus a sample stream back
interface scan_if;
	logic fast_mode;
	logic [7:0] in_use;
	logic [2:0] filter_sel;
	logic cfg_we;
	logic [2:0] cfg_ch;
	logic [2:0] cfg_range;
	logic signed [15:0] cfg_align;
	logic signed [15:0] cfg_low;
	logic signed [15:0] cfg_high;
	logic smp_valid;
	logic smp_ready;
	logic [2:0] smp_ch;
	logic signed [15:0] smp_value;
	logic [4:0] smp_status;
	logic cycle_done;
	modport dev (input fast_mode, in_use, filter_sel, cfg_we, cfg_ch, cfg_range, cfg_align, cfg_low, cfg_high,
		smp_ready, output smp_valid, smp_ch, smp_value, smp_status, cycle_done);
	modport host (output fast_mode, in_use, filter_sel, cfg_we, cfg_ch, cfg_range, cfg_align, cfg_low, cfg_high,
		smp_ready, input smp_valid, smp_ch, smp_value, smp_status, cycle_done);
endinterface
`default_nettype wire

/* File: src/sample_fifo.sv */
`timescale 1ns/10ps
`default_nettype none
module sample_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic push, pop;
	// Honest flags from the occupancy count
	always_comb begin
		in_ready = (cnt_r != (AW+1)'(DEPTH));
		out_valid = (cnt_r != '0);
		out_data = mem_r[rp_r];
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		wp_nxt = push ? wp_r + 1'b1 : wp_r;
		rp_nxt = pop ? rp_r + 1'b1 : rp_r;
		cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end
	// Storage has no reset; only occupancy decides what is valid
	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wp_r] <= in_data;
		end
	end
endmodule
`default_nettype wire

/* File: src/scan_host.sv */
`timescale 1ns/10ps
`default_nettype none
// Host end: drives config and keeps the latest value per channel
module scan_host (
	input wire logic clk,
	input wire logic reset_n,
	scan_if.host link,
	input wire logic fast_mode,
	input wire logic [7:0] in_use,
	input wire logic [2:0] filter_sel,
	input wire logic cfg_we,
	input wire logic [2:0] cfg_ch,
	input wire logic [2:0] cfg_range,
	input wire logic signed [15:0] cfg_align,
	input wire logic signed [15:0] cfg_low,
	input wire logic signed [15:0] cfg_high,
	input wire logic task_start,
	input wire logic [2:0] rd_ch,
	output logic signed [15:0] rd_value,
	output logic [4:0] rd_status
);
	logic signed [15:0] val_r [8];
	logic [4:0] st_r [8];
	logic signed [15:0] rdv_r, rdv_nxt;
	logic [4:0] rds_r, rds_nxt;
	logic [2:0] fsel_r;

	// Latch the filter setting only, capped at the last legal code; other config passes straight through
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fsel_r <= '0;
		end else begin
			fsel_r <= (filter_sel > scan_pkg::FILTER_MAX) ? scan_pkg::FILTER_MAX : filter_sel;
		end
	end
	assign link.fast_mode = fast_mode;
	assign link.in_use = in_use;
	assign link.filter_sel = fsel_r;
	assign link.cfg_we = cfg_we;
	assign link.cfg_ch = cfg_ch;
	assign link.cfg_range = cfg_range;
	assign link.cfg_align = cfg_align;
	assign link.cfg_low = cfg_low;
	assign link.cfg_high = cfg_high;
	assign link.smp_ready = 1'b1;

	// Mirror of newest samples; the task reads whatever is newest at its start
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < 8; i++) begin
				val_r[i] <= '0;
				st_r[i] <= '0;
			end
		end else if (link.smp_valid && link.smp_ready) begin
			val_r[link.smp_ch] <= link.smp_value;
			st_r[link.smp_ch] <= link.smp_status;
		end
	end
	always_comb begin
		rdv_nxt = task_start ? val_r[rd_ch] : rdv_r;
		rds_nxt = task_start ? st_r[rd_ch] : rds_r;
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdv_r <= '0;
			rds_r <= '0;
		end else begin
			rdv_r <= rdv_nxt;
			rds_r <= rds_nxt;
		end
	end
	assign rd_value = rdv_r;
	assign rd_status = rds_r;
endmodule
`default_nettype wire

/* File: verification/scan_link_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
// Watches the link between the host end and the scan engine
module scan_link_asserts (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic fast_mode,
	input wire logic [7:0] in_use,
	input wire logic cfg_we,
	input wire logic [2:0] cfg_ch,
	input wire logic signed [15:0] cfg_low,
	input wire logic signed [15:0] cfg_high,
	input wire logic smp_valid,
	input wire logic smp_ready,
	input wire logic [2:0] smp_ch,
	input wire logic signed [15:0] smp_value,
	input wire logic [4:0] smp_status,
	input wire logic cycle_done
);
	logic signed [15:0] lo_r [8];
	logic signed [15:0] hi_r [8];
	logic [2:0] last_r;
	logic seen_r, fresh_r, dseen_r, take;
	int cnt_r, exp_len;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	assign take = smp_valid && smp_ready;
	// Mode must only change under reset, or the length window below is meaningless
	always_comb exp_len = fast_mode ? ($countones(in_use) + 1) * scan_pkg::SLOT_CYCLES : 9 * scan_pkg::NORMAL_SLOT_CYCLES;
	// Shadow thresholds and history of the sample stream
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < 8; i++) begin
				lo_r[i] <= 16'sh8000;
				hi_r[i] <= 16'sh7fff;
			end
			last_r <= 3'h0;
			seen_r <= 1'b0;
			fresh_r <= 1'b0;
			dseen_r <= 1'b0;
			cnt_r <= 0;
		end else begin
			if (cfg_we) begin
				lo_r[cfg_ch] <= cfg_low;
				hi_r[cfg_ch] <= cfg_high;
			end
			if (take) begin
				last_r <= smp_ch;
				seen_r <= 1'b1;
				fresh_r <= 1'b0;
			end
			if (cycle_done) begin
				fresh_r <= 1'b1;
				dseen_r <= 1'b1;
				cnt_r <= 1;
			end else begin
				cnt_r <= cnt_r + 1;
			end
		end
	end
	sequence s_quiet;
		!cycle_done [*8];
	endsequence
	sequence s_hold;
		smp_valid && $stable(smp_ch) && $stable(smp_value) && $stable(smp_status);
	endsequence
	a_valid_holds: assert property (smp_valid && !smp_ready |=> s_hold)
		else $error("sample changed before it was taken");
	a_done_pulse: assert property (cycle_done |=> s_quiet)
		else $error("cycle end pulse too long");
	a_fast_in_use: assert property (take && fast_mode |-> in_use[smp_ch])
		else $error("unused channel scanned in fast cycle");
	a_normal_order: assert property (take && seen_r && !fast_mode |-> smp_ch == last_r + 3'h1)
		else $error("normal cycle channel order broken");
	a_fast_order: assert property (take && seen_r && fast_mode && !fresh_r |-> smp_ch > last_r)
		else $error("fast cycle channels not ascending");
	a_cycle_length: assert property (cycle_done && dseen_r |-> cnt_r >= exp_len - 4 && cnt_r <= exp_len + 4)
		else $error("scan cycle length wrong");
	a_over_clamp: assert property (take && smp_status[scan_pkg::ST_OVER] |-> smp_value == hi_r[smp_ch])
		else $error("overflow value not clamped");
	a_under_clamp: assert property (take && smp_status[scan_pkg::ST_UNDER] |-> smp_value == lo_r[smp_ch])
		else $error("underflow value not clamped");
	a_value_bounds: assert property (take |-> smp_value <= hi_r[smp_ch] && smp_value >= lo_r[smp_ch])
		else $error("value outside thresholds");
endmodule
`default_nettype wire

/* File: verification/analog_input_scan_sequencer_test.sv */
`timescale 1ns/10ps
`default_nettype none
module analog_input_scan_sequencer_test;
	logic clk = 1'b0, reset_n = 1'b0, fast_mode = 1'b0, cfg_we = 1'b0, task_start = 1'b0;
	logic term_present = 1'b1, conv_done = 1'b0, answer = 1'b1, ref_sel, conv_start, fault;
	logic [7:0] in_use = 8'hff;
	logic [2:0] filter_sel = 3'h0, cfg_ch = 3'h0, cfg_range = 3'h0, rd_ch = 3'h0, mux_sel, rng [8];
	logic [1:0] gain_sel;
	logic signed [15:0] cfg_align = 16'sh0, cfg_low = 16'sh8000, cfg_high = 16'sh7fff, conv_data = 16'sh0;
	logic signed [15:0] rd_value, got_v, raw [8];
	logic [4:0] rd_status, got_s;
	int num_errors = 0, n_checks = 0, cyc = 0, wait_c = 0, k;
	scan_if link ();
	scan_device scan_device_inst (.clk(clk), .reset_n(reset_n), .link(link.dev), .mux_sel(mux_sel), .ref_sel(ref_sel),
		.gain_sel(gain_sel), .conv_start(conv_start), .conv_done(conv_done), .conv_data(conv_data),
		.term_present(term_present), .fault(fault));
	scan_host scan_host_inst (.clk(clk), .reset_n(reset_n), .link(link.host), .fast_mode(fast_mode), .in_use(in_use),
		.filter_sel(filter_sel), .cfg_we(cfg_we), .cfg_ch(cfg_ch), .cfg_range(cfg_range), .cfg_align(cfg_align),
		.cfg_low(cfg_low), .cfg_high(cfg_high), .task_start(task_start), .rd_ch(rd_ch), .rd_value(rd_value),
		.rd_status(rd_status));
	scan_link_asserts scan_link_asserts_inst (.clk(clk), .reset_n(reset_n), .fast_mode(link.fast_mode),
		.in_use(link.in_use), .cfg_we(link.cfg_we), .cfg_ch(link.cfg_ch), .cfg_low(link.cfg_low),
		.cfg_high(link.cfg_high), .smp_valid(link.smp_valid), .smp_ready(link.smp_ready), .smp_ch(link.smp_ch),
		.smp_value(link.smp_value), .smp_status(link.smp_status), .cycle_done(link.cycle_done));
	always #12.5 clk = ~clk;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wrap_up;
		$display("checks=%0d errors=%0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Hang guard: the whole sequence needs well under half of this
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			wrap_up();
		end
	end
	// Converter stand-in: answers three cycles after a start, data babbles when not answering
	always @(negedge clk) begin
		conv_done <= (wait_c == 1) && answer;
		conv_data <= (wait_c == 1) ? (ref_sel ? 16'sh0 : raw[mux_sel]) : ~conv_data;
		if (wait_c > 0) wait_c--;
		if (conv_start) begin
			wait_c = 3;
			chk({14'h0, gain_sel}, ref_sel ? 16'h0 : rng[mux_sel] == scan_pkg::RANGE_BIP10 ? 16'h1 :
				(rng[mux_sel] == scan_pkg::RANGE_MA20 || rng[mux_sel] == scan_pkg::RANGE_MA4_20) ? 16'h2 : 16'h3);
		end
	end
	task cfg(input logic [2:0] ch, input logic [2:0] rg, input logic signed [15:0] al, lo, hi);
		@(negedge clk);
		{cfg_we, cfg_ch, cfg_range, cfg_align, cfg_low, cfg_high} = {1'b1, ch, rg, al, lo, hi};
		rng[ch] = rg;
		@(negedge clk);
		cfg_we = 1'b0;
	endtask
	// Waits for the next sample of one channel; held values are read a half cycle before the take
	task getc(input logic [2:0] ch);
		for (k = 0; k < 3000; k++) begin
			@(negedge clk);
			if (link.smp_valid && link.smp_ready && link.smp_ch == ch) break;
		end
		got_v = link.smp_value;
		got_s = link.smp_status;
	endtask
	initial begin
		for (int i = 0; i < 8; i++) begin
			raw[i] = 16'(i * 1000 + 100);
			rng[i] = scan_pkg::RANGE_BIP10;
		end
		repeat (8) @(negedge clk);
		reset_n = 1'b1;
		// Alignment on ch2, a low ceiling on ch3, a high floor on ch4
		cfg(3'h2, scan_pkg::RANGE_BIP10, 16'sh000a, 16'sh8000, 16'sh7fff);
		cfg(3'h3, scan_pkg::RANGE_BIP10, 16'sh0, 16'sh8000, 16'sh0100);
		cfg(3'h4, scan_pkg::RANGE_BIP10, 16'sh0, 16'sh1388, 16'sh7fff);
		for (int i = 0; i < 8; i++) begin
			getc(3'(i));
			chk(got_v, i == 3 ? 16'sh0100 : i == 4 ? 16'sh1388 : raw[i] + (i == 2 ? 16'sh000a : 16'sh0));
			chk({11'h0, got_s}, i == 3 ? 16'h2 : i == 4 ? 16'h1 : 16'h0);
		end
		// Step on ch0 with alpha 0.75: 100 then 1075 then 1806
		filter_sel = 3'h1;
		raw[0] = 16'sd4000;
		getc(3'h0);
		chk(got_v, 16'sh0433);
		getc(3'h0);
		chk(got_v, 16'sh070e);
		// Mode changes only under reset; a heavy filter setting must not slow the fast cycle
		reset_n = 1'b0;
		fast_mode = 1'b1;
		in_use = 8'h68;
		filter_sel = 3'h6;
		raw[3] = 16'sd2000;
		for (int i = 0; i < 8; i++) rng[i] = scan_pkg::RANGE_BIP10;
		repeat (3) @(negedge clk);
		reset_n = 1'b1;
		cfg(3'h5, scan_pkg::RANGE_MA4_20, 16'sh0, 16'sh8000, 16'sh7fff);
		cfg(3'h6, scan_pkg::RANGE_UNI5, 16'sh0, 16'sh8000, 16'sh7fff);
		getc(3'h3);
		chk(got_v, 16'sh07d0);
		raw[3] = -16'sd3000;
		getc(3'h3);
		chk(got_v, 16'shf448);
		// The mirror takes the sample at the coming edge; start the host task after it
		@(negedge clk);
		task_start = 1'b1;
		rd_ch = 3'h3;
		@(negedge clk);
		task_start = 1'b0;
		chk(rd_value, 16'shf448);
		chk({11'h0, rd_status}, 16'h0);
		// Terminal block pulled, then the converter falls silent
		term_present = 1'b0;
		getc(3'h3);
		chk({11'h0, got_s}, 16'(1 << scan_pkg::ST_TERM));
		chk({15'h0, fault}, 16'h0);
		answer = 1'b0;
		for (k = 0; k < 1200 && fault !== 1'b1; k++) @(negedge clk);
		chk({15'h0, fault}, 16'h1);
		wrap_up();
	end
endmodule
`default_nettype wire
